// >>> core/rag_gain_table.sv
`timescale 1ns/1ps
`default_nettype none
module rag_gain_table (
  input wire logic [4:0] addr_a,
  input wire logic [4:0] addr_b,
  output logic [6:0] data_a,
  output logic [6:0] data_b
);
  // level in half-dB of (index + 1), a coarse log of mean magnitude
  localparam logic [6:0] TBL [32] = '{
    7'h00, 7'h0C, 7'h13, 7'h18, 7'h1C, 7'h1F, 7'h22, 7'h24,
    7'h26, 7'h28, 7'h2A, 7'h2B, 7'h2D, 7'h2E, 7'h2F, 7'h30,
    7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h36, 7'h37,
    7'h38, 7'h39, 7'h39, 7'h3A, 7'h3A, 7'h3B, 7'h3C, 7'h3C
  };

  assign data_a = TBL[addr_a];
  assign data_b = TBL[addr_b];
endmodule : rag_gain_table
`default_nettype wire

// >>> core/rag_pkg.sv
package rag_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ------------------------------------------------------------
  localparam logic [7:0] RAG_OFF_CLIP = 8'h1E;
  localparam logic [7:0] RAG_OFF_SATCNT = 8'h20;
  localparam logic [7:0] RAG_OFF_UPDCTL = 8'h22;
  localparam logic [7:0] RAG_OFF_HISAT = 8'h24;
  localparam logic [7:0] RAG_OFF_LOCKIN = 8'h26;
  localparam logic [7:0] RAG_OFF_WINPOS = 8'h28;
  localparam logic [7:0] RAG_OFF_BACKOFF = 8'h2A;
  localparam logic [7:0] RAG_OFF_TADDR = 8'h2C;
  localparam logic [7:0] RAG_OFF_TDATA = 8'h2E;
  localparam logic [7:0] RAG_OFF_LGAIN = 8'h30;
  localparam logic [7:0] RAG_OFF_MANUAL = 8'h32;
  localparam logic [7:0] RAG_OFF_TEST = 8'h34;
  localparam logic [7:0] RAG_OFF_RFTHR = 8'h36;
  localparam logic [7:0] RAG_OFF_MIDLOW = 8'h38;
  localparam logic [7:0] RAG_OFF_WINNEG = 8'h3A;
  localparam int RAG_NREGS = 15;
  localparam logic [7:0] RAG_REG_RESET = 8'h00;

  // registers sit on every second byte address
  localparam int RAG_IX_CLIP = (RAG_OFF_CLIP - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_SATCNT = (RAG_OFF_SATCNT - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_UPDCTL = (RAG_OFF_UPDCTL - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_HISAT = (RAG_OFF_HISAT - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_LOCKIN = (RAG_OFF_LOCKIN - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_WINPOS = (RAG_OFF_WINPOS - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_BACKOFF = (RAG_OFF_BACKOFF - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_TADDR = (RAG_OFF_TADDR - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_TDATA = (RAG_OFF_TDATA - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_LGAIN = (RAG_OFF_LGAIN - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_MANUAL = (RAG_OFF_MANUAL - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_TEST = (RAG_OFF_TEST - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_RFTHR = (RAG_OFF_RFTHR - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_MIDLOW = (RAG_OFF_MIDLOW - RAG_OFF_CLIP) / 2;
  localparam int RAG_IX_WINNEG = (RAG_OFF_WINNEG - RAG_OFF_CLIP) / 2;

  // ------------------------------------------------------------
  // single-bit field positions
  // ------------------------------------------------------------
  localparam int RAG_B_CIR_UPD = 7;
  localparam int RAG_B_LUT_RD = 5;
  localparam int RAG_B_MAN_RF = 7;
  localparam int RAG_B_CONT = 7;
  localparam int RAG_B_POL = 6;
  localparam int RAG_B_XUPD_DIS = 5;
  localparam int RAG_B_VFY_DIS = 4;
  localparam int RAG_B_ROF = 3;
  localparam int RAG_B_OVR = 2;
  localparam int RAG_B_RAND = 1;
  localparam int RAG_B_THR_DIS = 7;

  // ------------------------------------------------------------
  // loop arithmetic
  // ------------------------------------------------------------
  localparam logic [7:0] RAG_REF_LEVEL = 8'h3C;
  localparam int RAG_MEAN_SHIFT = 5;
  localparam int RAG_GAIN_SHIFT = 6;
  localparam logic [5:0] RAG_SAT_POS = 6'h1F;
  localparam logic [5:0] RAG_SAT_NEG = 6'h20;
  localparam logic [6:0] RAG_PN_SEED = 7'h7F;

  typedef enum logic [0:0] {
    RAG_ACQ = 1'b0,
    RAG_LOCK = 1'b1
  } rag_lock_t;

endpackage : rag_pkg

// >>> core/rag_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rag_sync (
  input wire logic clk,
  input wire logic arst_n,
  output logic q
);
  logic s1_q;

  // releases reset two edges after the pin lets go
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_q <= 1'b1;
      q <= s1_q;
    end
  end
endmodule : rag_sync
`default_nettype wire

// >>> core/rag_top.sv
`timescale 1ns/1ps
`default_nettype none
module rag_top
  import rag_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic signed [5:0] RX_I,
  input wire logic signed [5:0] RX_Q,
  input wire logic CIR_INGEST,
  input wire logic FREEZE,
  input wire logic PN_ENABLE,
  input wire logic [7:0] CW_METRIC,
  output logic [6:0] IF_GAIN,
  output logic RF_PAD_CONTROL_OUTPUT,
  output logic GAIN_LOCKED_FLAG,
  output logic CONTINUOUS_TONE_DETECT,
  output logic [6:0] SIGNAL_LEVEL
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_n;

  rag_sync u_rst (
    .clk(MCLK),
    .arst_n(RESETN),
    .q(rst_n)
  );

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [7:0] reg_q [RAG_NREGS];
  logic hit;
  logic [3:0] idx;

  assign hit = !ADDR[0] && (ADDR >= RAG_OFF_CLIP) && (ADDR <= RAG_OFF_WINNEG);
  assign idx = 4'((ADDR - RAG_OFF_CLIP) >> 1);

  // all eight bits stored, spare ones only read back
  for (genvar g = 0; g < RAG_NREGS; g++) begin : g_reg
    always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
        reg_q[g] <= RAG_REG_RESET;
      end else if (WR && hit && idx == 4'(g)) begin
        reg_q[g] <= WDATA;
      end
    end
  end

  logic [6:0] clip_f, man_if, rf_thr, tbl_a, tbl_b;
  logic [3:0] mid_cnt, low_cnt, hi_cnt, mid_att, low_att;
  logic [4:0] hi_att, lock_in, win_pos, win_neg, taddr;
  logic [5:0] tmr_cnt, backoff;
  logic [2:0] cw_scale;
  logic cir_upd, lut_rd, man_rf, cont, pol, xupd_dis, vfy_dis;
  logic rof, ovr, rnd, thr_dis;

  assign clip_f = reg_q[RAG_IX_CLIP][6:0];
  assign mid_cnt = reg_q[RAG_IX_SATCNT][7:4];
  assign low_cnt = reg_q[RAG_IX_SATCNT][3:0];
  assign cir_upd = reg_q[RAG_IX_UPDCTL][RAG_B_CIR_UPD];
  assign tmr_cnt = reg_q[RAG_IX_UPDCTL][5:0];
  assign hi_att = reg_q[RAG_IX_HISAT][7:4] == 4'hF ? 5'h0F : {1'b0, reg_q[RAG_IX_HISAT][7:4]};
  assign hi_cnt = reg_q[RAG_IX_HISAT][3:0];
  assign cw_scale = reg_q[RAG_IX_LOCKIN][7:5];
  assign lock_in = reg_q[RAG_IX_LOCKIN][4:0];
  assign win_pos = reg_q[RAG_IX_WINPOS][4:0];
  assign backoff = reg_q[RAG_IX_BACKOFF][5:0];
  assign lut_rd = reg_q[RAG_IX_TADDR][RAG_B_LUT_RD];
  assign taddr = reg_q[RAG_IX_TADDR][4:0];
  assign man_rf = reg_q[RAG_IX_MANUAL][RAG_B_MAN_RF];
  assign man_if = reg_q[RAG_IX_MANUAL][6:0];
  assign cont = reg_q[RAG_IX_TEST][RAG_B_CONT];
  assign pol = reg_q[RAG_IX_TEST][RAG_B_POL];
  assign xupd_dis = reg_q[RAG_IX_TEST][RAG_B_XUPD_DIS];
  assign vfy_dis = reg_q[RAG_IX_TEST][RAG_B_VFY_DIS];
  assign rof = reg_q[RAG_IX_TEST][RAG_B_ROF];
  assign ovr = reg_q[RAG_IX_TEST][RAG_B_OVR];
  assign rnd = reg_q[RAG_IX_TEST][RAG_B_RAND];
  assign thr_dis = reg_q[RAG_IX_RFTHR][RAG_B_THR_DIS];
  assign rf_thr = reg_q[RAG_IX_RFTHR][6:0];
  assign mid_att = reg_q[RAG_IX_MIDLOW][7:4];
  assign low_att = reg_q[RAG_IX_MIDLOW][3:0];
  assign win_neg = reg_q[RAG_IX_WINNEG][4:0];

  // ------------------------------------------------------------
  // gain table and read port
  // ------------------------------------------------------------
  logic [4:0] lvl_idx;

  rag_gain_table u_tbl (
    .addr_a(taddr),
    .addr_b(lvl_idx),
    .data_a(tbl_a),
    .data_b(tbl_b)
  );

  // read data live for exactly one cycle, zero otherwise
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
    end else if (RD && hit) begin
      if (idx == 4'(RAG_IX_TDATA) && lut_rd) begin
        RDATA <= {1'b0, tbl_a};
      end else begin
        RDATA <= reg_q[idx];
      end
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // loop inputs and pseudo-noise source
  // ------------------------------------------------------------
  logic [6:0] pn_q;
  logic signed [5:0] s_i, s_q;

  // holding the seed while disabled gives the clear-then-set init
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pn_q <= RAG_PN_SEED;
    end else if (!PN_ENABLE) begin
      pn_q <= RAG_PN_SEED;
    end else begin
      pn_q <= {pn_q[5:0], pn_q[6] ^ pn_q[5]};
    end
  end

  assign s_i = (rnd && PN_ENABLE) ? pn_q[5:0] : RX_I;
  assign s_q = (rnd && PN_ENABLE) ? {pn_q[0], pn_q[6:2]} : RX_Q;

  function automatic logic [5:0] mag6(input logic [5:0] v);
    mag6 = v[5] ? 6'(-v) : v;
  endfunction : mag6

  function automatic logic is_sat(input logic [5:0] v);
    is_sat = (v == RAG_SAT_POS) || (v == RAG_SAT_NEG);
  endfunction : is_sat

  // ------------------------------------------------------------
  // cycle timer and accumulation
  // ------------------------------------------------------------
  logic [5:0] tmr_q;
  logic cyc_end;
  logic [12:0] sum_q;
  logic [6:0] satc_q;

  // timer values below 32 are not supported; 1 to 31 shorten the cycle, 0 gives a 64-clock cycle
  assign cyc_end = tmr_q >= 6'(tmr_cnt - 6'h01);

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= 6'h00;
    end else begin
      tmr_q <= cyc_end ? 6'h00 : 6'(tmr_q + 6'h01);
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      sum_q <= 13'h0000;
      satc_q <= 7'h00;
    end else if (cyc_end) begin
      sum_q <= 13'h0000;
      satc_q <= 7'h00;
    end else begin
      sum_q <= 13'(sum_q + mag6(s_i) + mag6(s_q));
      satc_q <= 7'(satc_q + is_sat(s_i) + is_sat(s_q));
    end
  end

  // ------------------------------------------------------------
  // error, correction and attenuation step
  // ------------------------------------------------------------
  logic [7:0] mean;
  logic signed [7:0] err;
  logic [7:0] err_mag;
  logic signed [15:0] prod;
  logic signed [7:0] corr;
  logic [6:0] step;
  logic signed [9:0] nxt_raw;
  logic [6:0] acc_q, acc_nx;

  assign mean = 8'(sum_q >> RAG_MEAN_SHIFT);
  assign lvl_idx = (mean[7:2] > 6'h1F) ? 5'h1F : mean[6:2];
  // positive error asks for more attenuation
  assign err = 8'({1'b0, tbl_b} + {2'b00, backoff} - RAG_REF_LEVEL);
  assign err_mag = err[7] ? 8'(-err) : err;
  assign prod = err * $signed({1'b0, reg_q[RAG_IX_LGAIN][6:0]});
  assign corr = 8'(prod >>> RAG_GAIN_SHIFT);

  always_comb begin
    if (satc_q > {3'b000, hi_cnt}) begin
      step = {1'b0, hi_att, 1'b0};
    end else if (satc_q > {3'b000, mid_cnt}) begin
      step = {2'b00, mid_att, 1'b0};
    end else if (satc_q > {3'b000, low_cnt}) begin
      step = {3'b000, low_att};
    end else begin
      step = 7'h00;
    end
  end

  // a saturation step replaces the linear correction for that cycle
  assign nxt_raw = (step != 7'h00) ? $signed({3'b000, acc_q}) + $signed({3'b000, step})
                                   : $signed({3'b000, acc_q}) + 10'(corr);

  always_comb begin
    if (nxt_raw < 10'sh000) begin
      acc_nx = 7'h00;
    end else if (nxt_raw > $signed({3'b000, clip_f})) begin
      acc_nx = clip_f;
    end else begin
      acc_nx = nxt_raw[6:0];
    end
  end

  // ------------------------------------------------------------
  // lock tracking
  // ------------------------------------------------------------
  rag_lock_t state_q, state_d;
  logic vfy_q, run, in_inner, out_outer, lock_decl;

  assign run = !FREEZE || rof;
  assign in_inner = (err_mag <= {3'b000, lock_in}) && (step == 7'h00);
  assign out_outer = (err > $signed({3'b000, win_pos}))
                     || (err < -$signed({2'b00, win_neg, 1'b0}));
  assign lock_decl = (state_q == RAG_ACQ) && cyc_end && run && in_inner && (vfy_dis || vfy_q);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RAG_ACQ: begin
        if (lock_decl) begin
          state_d = RAG_LOCK;
        end
      end
      RAG_LOCK: begin
        if (cyc_end && run && out_outer) begin
          state_d = RAG_ACQ;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RAG_ACQ;
      GAIN_LOCKED_FLAG <= 1'b0;
    end else begin
      state_q <= state_d;
      GAIN_LOCKED_FLAG <= (state_d == RAG_LOCK);
    end
  end

  // one earlier in-window cycle is needed before lock when verifying
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      vfy_q <= 1'b0;
    end else if (cyc_end && run) begin
      vfy_q <= in_inner && (state_q == RAG_ACQ);
    end
  end

  // ------------------------------------------------------------
  // gain accumulator update
  // ------------------------------------------------------------
  logic mode_ok, cir_ok, upd_en;

  assign mode_ok = ((state_q == RAG_ACQ) && !FREEZE) || (cont && rof);
  assign cir_ok = !CIR_INGEST || cir_upd;
  assign upd_en = cyc_end && cir_ok && (mode_ok || (lock_decl && !xupd_dis));

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 7'h00;
    end else if (upd_en) begin
      acc_q <= acc_nx;
    end else if (acc_q > clip_f) begin
      acc_q <= clip_f;
    end
  end

  // estimate keeps moving under run-on-freeze even when gain is held
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      SIGNAL_LEVEL <= 7'h00;
    end else if (cyc_end && run) begin
      SIGNAL_LEVEL <= tbl_b;
    end
  end

  // ------------------------------------------------------------
  // front-end gain outputs and tone detect
  // ------------------------------------------------------------
  logic pad_remove;

  assign pad_remove = ovr ? man_rf : (!thr_dis && (acc_q < rf_thr));

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      IF_GAIN <= 7'h00;
      RF_PAD_CONTROL_OUTPUT <= 1'b0;
    end else begin
      IF_GAIN <= ovr ? man_if : acc_q;
      RF_PAD_CONTROL_OUTPUT <= pad_remove ^ pol;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      CONTINUOUS_TONE_DETECT <= 1'b0;
    end else begin
      CONTINUOUS_TONE_DETECT <= (cw_scale == 3'h0)
                                || (CW_METRIC >= 8'({3'b000, lock_in} * {5'b00000, cw_scale}));
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_clip;
    @(posedge MCLK) disable iff (!rst_n) 1'b1 |=> acc_q <= $past(clip_f);
  endproperty
  a_clip: assert property (p_clip) else $error("gain above clip");

  property p_ovr_if;
    @(posedge MCLK) disable iff (!rst_n) ovr |=> IF_GAIN == $past(man_if);
  endproperty
  a_ovr_if: assert property (p_ovr_if) else $error("override IF gain wrong");

  property p_ovr_rf;
    @(posedge MCLK) disable iff (!rst_n) ovr |=> RF_PAD_CONTROL_OUTPUT == ($past(man_rf) ^ $past(pol));
  endproperty
  a_ovr_rf: assert property (p_ovr_rf) else $error("manual RF control wrong");

  property p_thr;
    @(posedge MCLK) disable iff (!rst_n) (!ovr && !thr_dis && acc_q < rf_thr) |=> RF_PAD_CONTROL_OUTPUT == !$past(pol);
  endproperty
  a_thr: assert property (p_thr) else $error("pad not removed below threshold");

  property p_lut;
    @(posedge MCLK) disable iff (!rst_n) (RD && hit && idx == 4'(RAG_IX_TDATA) && lut_rd) |=> RDATA == {1'b0, $past(tbl_a)};
  endproperty
  a_lut: assert property (p_lut) else $error("table read wrong");

  property p_hi_step;
    @(posedge MCLK) disable iff (!rst_n)
      (upd_en && satc_q > {3'b000, hi_cnt} && nxt_raw <= $signed({3'b000, clip_f}))
      |=> acc_q == 7'($past(acc_q) + {$past(hi_att), 1'b0});
  endproperty
  a_hi_step: assert property (p_hi_step) else $error("high step wrong");

  property p_cir;
    @(posedge MCLK) disable iff (!rst_n) (cyc_end && CIR_INGEST && !cir_upd && acc_q <= clip_f) |=> $stable(acc_q);
  endproperty
  a_cir: assert property (p_cir) else $error("gain moved during ingest");

  property p_extra;
    @(posedge MCLK) disable iff (!rst_n) (lock_decl && !xupd_dis && cir_ok) |=> acc_q == $past(acc_nx);
  endproperty
  a_extra: assert property (p_extra) else $error("missing lock update");

  property p_verify;
    @(posedge MCLK) disable iff (!rst_n) (state_q == RAG_ACQ && !vfy_dis && !vfy_q) |=> state_q == RAG_ACQ;
  endproperty
  a_verify: assert property (p_verify) else $error("lock without verify");

  property p_cw;
    @(posedge MCLK) disable iff (!rst_n) (cw_scale == 3'h0) |=> CONTINUOUS_TONE_DETECT;
  endproperty
  a_cw: assert property (p_cw) else $error("tone detect not forced");

endmodule : rag_top
`default_nettype wire

// >>> tb/rag_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
module rag_fe_model (
  input wire logic clk,
  input wire logic [3:0] sat_every,
  output logic signed [5:0] rx_i,
  output logic signed [5:0] rx_q
);
  // ------------------------------------------------------------
  // converter samples
  // ------------------------------------------------------------
  // full scale every sat_every clocks, zero otherwise; Q clips only
  // at a period of one so a known count of clips lands in each cycle
  logic [3:0] ph_q = 4'h0;
  always_ff @(posedge clk) begin
    ph_q <= (ph_q + 4'h1 >= sat_every) ? 4'h0 : ph_q + 4'h1;
  end
  always_comb begin
    rx_i = (sat_every != 4'h0 && ph_q == 4'h0) ? 6'sh1F : 6'sh00;
    rx_q = (sat_every == 4'h1) ? 6'sh1F : 6'sh00;
  end
endmodule : rag_fe_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import rag_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic ingest = 1'b0;
  logic freeze = 1'b0;
  logic [7:0] tone_metric = 8'h00;
  logic [3:0] sat_every = 4'h0;
  logic signed [5:0] rx_i;
  logic signed [5:0] rx_q;
  logic [7:0] rdata;
  logic [6:0] if_gain;
  logic rf_pad;
  logic tone_det;
  logic [7:0] s_if;
  logic [7:0] s_rf;
  logic [7:0] s_tone;
  logic pn_en = 1'b0;
  logic locked;
  logic [6:0] sig_lvl;
  logic [7:0] s_lock;
  logic [7:0] s_lvl;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;

  rag_top u_dut (.MCLK(mclk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .RX_I(rx_i), .RX_Q(rx_q), .CIR_INGEST(ingest), .FREEZE(freeze), .PN_ENABLE(pn_en),
    .CW_METRIC(tone_metric), .IF_GAIN(if_gain), .RF_PAD_CONTROL_OUTPUT(rf_pad),
    .GAIN_LOCKED_FLAG(locked), .CONTINUOUS_TONE_DETECT(tone_det), .SIGNAL_LEVEL(sig_lvl));
  rag_fe_model u_fe (.clk(mclk), .sat_every(sat_every), .rx_i(rx_i), .rx_q(rx_q));

  always #2.5 mclk = ~mclk;

  // ------------------------------------------------------------
  // hang guard and closing report
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // bus and sampling helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // idle cycle after each strobe so no strobe is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    @(negedge mclk);
    d = rdata;
    @(posedge mclk);
  endtask : rd

  task automatic snap();
    @(negedge mclk);
    s_if = {1'b0, if_gain};
    s_rf = {7'h00, rf_pad};
    s_tone = {7'h00, tone_det};
    s_lock = {7'h00, locked};
    s_lvl = {1'b0, sig_lvl};
    @(posedge mclk);
  endtask : snap

  task automatic wait_chg(output logic [7:0] v);
    logic [6:0] v0;
    @(negedge mclk);
    v0 = if_gain;
    for (int k = 0; k < 120; k++) begin
      @(negedge mclk);
      if (if_gain !== v0) break;
    end
    v = {1'b0, if_gain};
    @(posedge mclk);
  endtask : wait_chg

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic do_reset();
    resetn <= 1'b0;
    sat_every <= 4'h0;
    ingest <= 1'b0;
    freeze <= 1'b0;
    pn_en <= 1'b0;
    tick(8);
    resetn <= 1'b1;
    tick(3);
  endtask : do_reset

  function automatic logic [7:0] pat(input int i);
    return {~4'(i), 4'(i)};
  endfunction : pat

  // high step 3 over count 15, mid count 5, low count 3, mid 2, low 7
  task automatic loop_cfg(input logic [7:0] upd);
    wr(RAG_OFF_UPDCTL, upd);
    wr(RAG_OFF_CLIP, 8'h7F);
    wr(RAG_OFF_HISAT, 8'h3F);
    wr(RAG_OFF_SATCNT, 8'h53);
    wr(RAG_OFF_MIDLOW, 8'h27);
    wr(RAG_OFF_BACKOFF, 8'h3F);
  endtask : loop_cfg

  // zero input gives an error of +2 half-dB; loop gain 1.0, window +4
  // freeze first so no cycle end runs the loop before the test bits land
  task automatic lock_cfg(input logic [7:0] tst);
    freeze <= 1'b1;
    wr(RAG_OFF_UPDCTL, 8'h20);
    wr(RAG_OFF_CLIP, 8'h7F);
    wr(RAG_OFF_BACKOFF, 8'h3E);
    wr(RAG_OFF_LOCKIN, 8'h04);
    wr(RAG_OFF_LGAIN, 8'h40);
    wr(RAG_OFF_WINPOS, 8'h04);
    wr(RAG_OFF_TEST, tst);
  endtask : lock_cfg

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < RAG_NREGS; i++) begin
      rd(RAG_OFF_CLIP + 8'(2 * i), d);
      chk("reset value", RAG_REG_RESET, d);
    end
    for (int i = 0; i < RAG_NREGS; i++) wr(RAG_OFF_CLIP + 8'(2 * i), pat(i));
    for (int i = 0; i < RAG_NREGS; i++) begin
      rd(RAG_OFF_CLIP + 8'(2 * i), d);
      chk("readback", pat(i), d);
    end
    wr(8'h3C, 8'hFF);
    rd(8'h3C, d);
    chk("unmapped", 8'h00, d);
    rd(8'h1F, d);
    chk("odd addr", 8'h00, d);
    wr(RAG_OFF_TADDR, 8'h25);
    rd(RAG_OFF_TDATA, d);
    chk("table msb", 8'h00, d & 8'h80);
    chk("table sel", 8'h00, {7'h00, d == pat(RAG_IX_TDATA)});
    wr(RAG_OFF_TADDR, 8'h05);
    rd(RAG_OFF_TDATA, d);
    chk("table own", pat(RAG_IX_TDATA), d);
  endtask : t_regs

  task automatic t_override();
    do_reset();
    wr(RAG_OFF_TEST, 8'h04);
    wr(RAG_OFF_MANUAL, 8'h85);
    snap();
    chk("manual if", 8'h05, s_if);
    chk("manual rf", 8'h01, s_rf);
    wr(RAG_OFF_MANUAL, 8'h05);
    snap();
    chk("manual rf", 8'h00, s_rf);
    wr(RAG_OFF_TEST, 8'h44);
    snap();
    chk("inverted rf", 8'h01, s_rf);
    loop_cfg(8'h20);
    sat_every <= 4'h1;
    tick(200);
    snap();
    chk("manual if", 8'h05, s_if);
  endtask : t_override

  task automatic t_steps();
    logic [7:0] a;
    logic [7:0] b;
    do_reset();
    loop_cfg(8'h20);
    sat_every <= 4'h1;
    wait_chg(a);
    chk("high step", 8'h06, a);
    sat_every <= 4'h4;
    wait_chg(a);
    wait_chg(a);
    wait_chg(b);
    chk("mid step", a + 8'h04, b);
    wr(RAG_OFF_SATCNT, 8'h93);
    wait_chg(a);
    wait_chg(b);
    chk("low step", a + 8'h07, b);
    wr(RAG_OFF_CLIP, 8'h40);
    sat_every <= 4'h1;
    tick(900);
    snap();
    chk("clip", 8'h40, s_if);
  endtask : t_steps

  task automatic t_hold();
    logic [7:0] a;
    do_reset();
    ingest <= 1'b1;
    loop_cfg(8'h20);
    sat_every <= 4'h1;
    tick(300);
    snap();
    chk("ingest hold", 8'h00, s_if);
    wr(RAG_OFF_UPDCTL, 8'hA0);
    wait_chg(a);
    chk("ingest run", 8'h06, a);
    ingest <= 1'b0;
    freeze <= 1'b1;
    wr(RAG_OFF_TEST, 8'h08);
    tick(40);
    snap();
    tick(300);
    a = s_if;
    snap();
    chk("freeze hold", a, s_if);
    wr(RAG_OFF_TEST, 8'h88);
    wait_chg(a);
    chk("cont update", s_if + 8'h06, a);
  endtask : t_hold

  task automatic t_pad_tone();
    do_reset();
    wr(RAG_OFF_UPDCTL, 8'h20);
    wr(RAG_OFF_RFTHR, 8'h10);
    tick(80);
    snap();
    chk("pad removed", 8'h01, s_rf);
    wr(RAG_OFF_RFTHR, 8'h00);
    tick(80);
    snap();
    chk("pad kept", 8'h00, s_rf);
    wr(RAG_OFF_RFTHR, 8'h90);
    tick(80);
    snap();
    chk("thr disabled", 8'h00, s_rf);
    wr(RAG_OFF_RFTHR, 8'h10);
    wr(RAG_OFF_TEST, 8'h40);
    tick(80);
    snap();
    chk("pad inverted", 8'h00, s_rf);
    tick(80);
    snap();
    chk("tone forced", 8'h01, s_tone);
    wr(RAG_OFF_LOCKIN, 8'h21);
    tick(80);
    snap();
    chk("tone low", 8'h00, s_tone);
    tone_metric <= 8'hFF;
    tick(80);
    snap();
    chk("tone high", 8'h01, s_tone);
  endtask : t_pad_tone

  task automatic t_lock();
    do_reset();
    lock_cfg(8'h08);
    tick(30);
    snap();
    chk("verify wait", 8'h00, s_lock);
    chk("no freeze update", 8'h00, s_if);
    tick(30);
    snap();
    chk("locked", 8'h01, s_lock);
    chk("extra update", 8'h02, s_if);
    tick(70);
    snap();
    chk("lock kept", 8'h01, s_lock);
    chk("lock hold", 8'h02, s_if);
    wr(RAG_OFF_WINNEG, 8'h03);
    wr(RAG_OFF_BACKOFF, 8'h36);
    tick(70);
    snap();
    chk("neg side in", 8'h01, s_lock);
    wr(RAG_OFF_WINNEG, 8'h02);
    tick(70);
    snap();
    chk("neg side out", 8'h00, s_lock);
    do_reset();
    lock_cfg(8'h38);
    tick(30);
    snap();
    chk("no verify", 8'h01, s_lock);
    chk("no extra", 8'h00, s_if);
  endtask : t_lock

  task automatic t_pn();
    do_reset();
    freeze <= 1'b1;
    pn_en <= 1'b1;
    wr(RAG_OFF_UPDCTL, 8'h20);
    wr(RAG_OFF_TEST, 8'h02);
    tick(80);
    snap();
    chk("level frozen", 8'h00, s_lvl);
    wr(RAG_OFF_TEST, 8'h08);
    tick(80);
    snap();
    chk("level quiet", 8'h00, s_lvl);
    wr(RAG_OFF_TEST, 8'h0A);
    tick(80);
    snap();
    chk("level random", 8'h01, {7'h00, s_lvl != 8'h00});
  endtask : t_pn

  initial begin
    @(posedge mclk);
    do_reset();
    t_regs();
    t_override();
    t_steps();
    t_hold();
    t_pad_tone();
    t_lock();
    t_pn();
    end_sim();
  end
endmodule : tb
`default_nettype wire
